//--- rtl/switch_ctrl_defines.svh
`ifndef SWITCH_CTRL_DEFINES_SVH
`define SWITCH_CTRL_DEFINES_SVH
// channel count per device
`define CHAN_COUNT 4
// system clock period in ns (25 MHz)
`define SYS_CLK_NS 40
// link clock half period in system clocks for the controller divider
`define LINK_HALF_DIV 8'h04
// controller waits between last rising link edge and latch rise
`define LATCH_GAP_NS 400
`define LATCH_GAP_CYC (((`LATCH_GAP_NS) + (`SYS_CLK_NS) - 1) / (`SYS_CLK_NS) + 1)
// latch high time held by the controller
`define LATCH_HIGH_NS 200
`define LATCH_HIGH_CYC (((`LATCH_HIGH_NS) + (`SYS_CLK_NS) - 1) / (`SYS_CLK_NS))
// overcurrent deglitch, 3.5 us, in tenths of a microsecond
`define OC_DEGLITCH_TENTH_US 35
`define OC_DEGLITCH_CYC ((`OC_DEGLITCH_TENTH_US) * 1000 / 10 / (`SYS_CLK_NS))
// overcurrent retry, 1.2 ms, in tenths of a millisecond
`define OC_RETRY_TENTH_MS 12
`define OC_RETRY_CYC ((`OC_RETRY_TENTH_MS) * 100000 / (`SYS_CLK_NS))
// controller waits 55 us after power and after reset; reset pin held 20 us
`define POWERUP_WAIT_US 55
`define POWERUP_WAIT_CYC ((`POWERUP_WAIT_US) * 1000 / (`SYS_CLK_NS))
`define RESET_WAIT_US 20
`define RESET_WAIT_CYC ((`RESET_WAIT_US) * 1000 / (`SYS_CLK_NS))
`endif

//--- rtl/switch_ctrl_pkg.sv
`default_nettype none
package switch_ctrl_pkg;
  typedef logic [3:0] chan_t;
  typedef enum logic [3:0] {
    CTL_WAIT  = 4'h1,
    CTL_IDLE  = 4'h2,
    CTL_SHIFT = 4'h4,
    CTL_LATCH = 4'h8
  } ctl_state_e;
endpackage : switch_ctrl_pkg
`default_nettype wire

//--- rtl/switch_dev_core.sv
// Summary of operation
// R1 - shift one bit per rising clock
// R2 - chain output changes on falling edge
// R3 - four holding bits set four channels
// R4 - two devices need eight bits
// R5 - chain output feeds next device input
// R6 - latch rise copies holding to outputs
// R7 - shifting ignores latch level
// R8 - over 400 ns clock-to-latch gap
// R9 - channel on when bit set, enabled
// R10 - disable pin blocks outputs only
// R11 - reset pin clears logic and faults
// R12 - internal power-up reset provided
// R13 - wait 20 us around reset
// R14 - wait 55 us after power
// R15 - 3.5 us overcurrent trips channel, fault
// R16 - 1.2 ms retry then auto clear
// R17 - reset or power cycle clears fault
// R18 - overheating disables all, flags fault
// R19 - undervoltage resets and disables all
// R20 - channels off after any reset
// R21 - last bit shifted drives channel one
`include "switch_ctrl_defines.svh"
`default_nettype none
module switch_dev_core #(
  parameter int RETRY_CYC = `OC_RETRY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire switch_ctrl_pkg::chan_t overcurrent_trip_i,
  input wire logic thermal_trip_i,
  input wire logic supply_low_lockout_i,
  output switch_ctrl_pkg::chan_t chan_on_o,
  switch_link_if.device link
);
  import switch_ctrl_pkg::*;

  localparam int DG_CYC = `OC_DEGLITCH_CYC;

  ////////////////////////////////////////////////////////////
  // logic reset: power-up (resetn_i), reset pin, undervoltage
  logic logic_rst;
  // R11 R12 R19 combined reset
  assign logic_rst = !resetn_i || link.reset_pin || supply_low_lockout_i;

  // link clock idles low around release, so the link side releases
  // directly; a synchroniser there would swallow the first two bits
  logic [1:0] srst_q;
  always_ff @(posedge sys_clk_i or posedge logic_rst) begin
    if (logic_rst) begin
      srst_q <= 2'b00;
    end else begin
      srst_q <= {srst_q[0], 1'b1};
    end
  end
  logic srst_n;
  assign srst_n = srst_q[1];

  ////////////////////////////////////////////////////////////
  // link domain
  chan_t hold_q;
  logic out_q;
  // R1 R3 R7 shift on rising edge, latch level ignored
  always_ff @(posedge link.link_clk or posedge logic_rst) begin
    if (logic_rst) begin
      hold_q <= 4'h0;
    end else begin
      // R21 newest bit in bit 0 = channel one
      hold_q <= {hold_q[2:0], link.chain_in};
    end
  end
  // R2 R5 bit leaving holding register, on falling edge
  always_ff @(negedge link.link_clk or posedge logic_rst) begin
    if (logic_rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= hold_q[3];
    end
  end
  assign link.chain_out = out_q;

  ////////////////////////////////////////////////////////////
  // latch: holding register is stable after the gap (R8), so
  // the latch edge is taken in the system domain
  logic [2:0] lat_sync_q;
  logic [2:0] dis_sync_q;
  logic [2:0] hold_sync0_q [4];
  chan_t out_stage_q;
  logic dis_q, lat_lvl_q;
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      lat_sync_q <= 3'b000;
      dis_sync_q <= 3'b111;
      dis_q <= 1'b1;
      lat_lvl_q <= 1'b0;
    end else begin
      lat_sync_q <= {lat_sync_q[1:0], link.latch};
      dis_sync_q <= {dis_sync_q[1:0], link.drive_disable_pin};
      if (lat_sync_q[2] == lat_sync_q[1]) begin
        lat_lvl_q <= lat_sync_q[2];
      end
      if (dis_sync_q[2] == dis_sync_q[1]) begin
        dis_q <= dis_sync_q[2];
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      for (int g = 0; g < `CHAN_COUNT; g++) begin
        hold_sync0_q[g] <= 3'b000;
      end
    end else begin
      for (int g = 0; g < `CHAN_COUNT; g++) begin
        hold_sync0_q[g] <= {hold_sync0_q[g][1:0], hold_q[g]};
      end
    end
  end
  logic lat_rise;
  assign lat_rise = (lat_sync_q[2] == lat_sync_q[1]) && lat_sync_q[2] && !lat_lvl_q;
  // R6 R20 copy on latch rise, cleared by reset
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      out_stage_q <= 4'h0;
    end else if (lat_rise) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        out_stage_q[i] <= hold_sync0_q[i][2];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // overcurrent per channel
  logic [11:0] dg_q [4];
  logic [15:0] rt_q [4];
  chan_t oc_fault_q;
  // R15 R16 R17 deglitch, trip, retry, reset clears
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        dg_q[i] <= 12'h000;
        rt_q[i] <= 16'h0000;
      end
      oc_fault_q <= 4'h0;
    end else begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        if (oc_fault_q[i]) begin
          dg_q[i] <= 12'h000;
          if (rt_q[i] >= 16'(RETRY_CYC - 1)) begin
            oc_fault_q[i] <= 1'b0;
            rt_q[i] <= 16'h0000;
          end else begin
            rt_q[i] <= rt_q[i] + 16'h0001;
          end
        end else if (overcurrent_trip_i[i]) begin
          if (dg_q[i] >= 12'(DG_CYC - 1)) begin
            oc_fault_q[i] <= 1'b1;
            dg_q[i] <= 12'h000;
          end else begin
            dg_q[i] <= dg_q[i] + 12'h001;
          end
        end else begin
          dg_q[i] <= 12'h000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs
  logic flt_q;
  // R9 R10 R18 R19 gate channels
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      chan_on_o <= 4'h0;
    end else if (dis_q || thermal_trip_i) begin
      chan_on_o <= 4'h0;
    end else begin
      chan_on_o <= out_stage_q & ~oc_fault_q;
    end
  end
  // R15 R18 fault pin pulled low
  always_ff @(posedge sys_clk_i or negedge srst_n) begin
    if (!srst_n) begin
      flt_q <= 1'b0;
    end else begin
      flt_q <= (|oc_fault_q) || thermal_trip_i;
    end
  end
  assign link.fault_flag_low_o = 1'b0;
  assign link.fault_flag_low_oe = flt_q;
endmodule : switch_dev_core
`default_nettype wire

//--- rtl/switch_host_ctrl.sv
`include "switch_ctrl_defines.svh"
`default_nettype none
module switch_host_ctrl (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire switch_ctrl_pkg::chan_t pattern_i,
  input wire logic write_i,
  input wire logic disable_i,
  input wire logic reset_dev_i,
  output logic busy_o,
  output logic fault_o,
  switch_link_if.host link
);
  import switch_ctrl_pkg::*;

  localparam int PU_CYC = `POWERUP_WAIT_CYC;
  localparam int RS_CYC = `RESET_WAIT_CYC;
  localparam int GAP_CYC = `LATCH_GAP_CYC;
  localparam int LH_CYC = `LATCH_HIGH_CYC;

  ctl_state_e state_q;
  logic [15:0] wait_q;
  logic [7:0] div_q;
  logic [2:0] bits_q;
  chan_t data_q;
  logic clk_q, sdo_q, latch_q, dis_q, rst_q;
  logic [2:0] flt_q;

  ////////////////////////////////////////////////////////////
  // R14 R13 wait after power and reset, R4 shift 4 bits, R8 gap
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= CTL_WAIT;
      wait_q <= 16'h0000;
      div_q <= 8'h00;
      bits_q <= 3'h0;
      data_q <= 4'h0;
      clk_q <= 1'b0;
      sdo_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      case (state_q)
        CTL_WAIT: begin
          clk_q <= 1'b0;
          latch_q <= 1'b0;
          // reset pin is held for the reset wait, then the restart wait runs
          if (rst_q && wait_q >= 16'(RS_CYC)) begin
            wait_q <= 16'h0000;
          end else if (!rst_q && wait_q >= 16'(PU_CYC > RS_CYC ? PU_CYC : RS_CYC)) begin
            state_q <= CTL_IDLE;
          end else begin
            wait_q <= wait_q + 16'h0001;
          end
        end
        CTL_IDLE: begin
          if (reset_dev_i) begin
            state_q <= CTL_WAIT;
            wait_q <= 16'h0000;
          end else if (write_i) begin
            // R21 msb first, last bit lands on channel one
            data_q <= pattern_i;
            sdo_q <= pattern_i[3];
            bits_q <= 3'h0;
            div_q <= 8'h00;
            state_q <= CTL_SHIFT;
          end
        end
        CTL_SHIFT: begin
          if (div_q == `LINK_HALF_DIV - 8'h01) begin
            div_q <= 8'h00;
            clk_q <= ~clk_q;
            if (clk_q) begin
              // falling edge: present next bit
              data_q <= {data_q[2:0], 1'b0};
              sdo_q <= data_q[2];
              if (bits_q == 3'h3) begin
                state_q <= CTL_LATCH;
                wait_q <= 16'h0000;
              end
              bits_q <= bits_q + 3'h1;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        CTL_LATCH: begin
          wait_q <= wait_q + 16'h0001;
          latch_q <= (wait_q >= 16'(GAP_CYC)) && (wait_q < 16'(GAP_CYC + LH_CYC));
          if (wait_q >= 16'(GAP_CYC + LH_CYC)) begin
            latch_q <= 1'b0;
            state_q <= CTL_IDLE;
          end
        end
        default: state_q <= CTL_WAIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dis_q <= 1'b1;
      rst_q <= 1'b0;
      busy_o <= 1'b1;
    end else begin
      dis_q <= disable_i;
      // R13 reset pin stretched to the minimum pulse
      rst_q <= (state_q == CTL_IDLE && reset_dev_i) || (rst_q && wait_q < 16'(RS_CYC));
      busy_o <= (state_q != CTL_IDLE) || write_i;
    end
  end

  // fault pin from outside domain: three stages, agree on last two
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flt_q <= 3'b111;
      fault_o <= 1'b0;
    end else begin
      flt_q <= {flt_q[1:0], ~link.fault_flag_low_oe};
      if (flt_q[2] == flt_q[1]) begin
        fault_o <= ~flt_q[2];
      end
    end
  end

  assign link.link_clk = clk_q;
  assign link.chain_in = sdo_q;
  assign link.latch = latch_q;
  assign link.drive_disable_pin = dis_q;
  assign link.reset_pin = rst_q;
endmodule : switch_host_ctrl
`default_nettype wire

//--- rtl/switch_link_if.sv
`default_nettype none
interface switch_link_if;
  logic link_clk;
  logic chain_in;
  logic chain_out;
  logic latch;
  logic drive_disable_pin;
  logic reset_pin;
  logic fault_flag_low_o;
  logic fault_flag_low_oe;
  modport device (
    input link_clk, chain_in, latch, drive_disable_pin, reset_pin,
    output chain_out, fault_flag_low_o, fault_flag_low_oe
  );
  modport host (
    output link_clk, chain_in, latch, drive_disable_pin, reset_pin,
    input chain_out, fault_flag_low_o, fault_flag_low_oe
  );
endinterface : switch_link_if
`default_nettype wire

//--- testbench/switch_link_properties.sv
`default_nettype none
module switch_link_properties (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic supply_low_lockout_i,
  input wire logic thermal_trip_i,
  input wire switch_ctrl_pkg::chan_t chan_on_o,
  input wire logic link_clk,
  input wire logic chain_in,
  input wire logic chain_out,
  input wire logic latch,
  input wire logic drive_disable_pin,
  input wire logic reset_pin,
  input wire logic fault_flag_low_oe
);
  import switch_ctrl_pkg::*;
  logic clr;
  logic [2:0] rises_q;
  assign clr = !resetn_i || reset_pin || supply_low_lockout_i;
  ////////////////////////////////////////////////////////////////
  // counts rises since reset, so stale history is never compared
  always_ff @(posedge link_clk or posedge clr) begin
    if (clr) begin
      rises_q <= 3'h0;
    end else if (rises_q != 3'h4) begin
      rises_q <= rises_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_shift_four_deep: assert property (@(posedge link_clk) disable iff (clr)
    rises_q == 3'h4 |-> chain_out == $past(chain_in, 4))
    else $error("chain output is not input delayed by four bits");
  a_out_held_high: assert property (@(posedge sys_clk_i) disable iff (clr)
    link_clk && $past(link_clk) |-> $stable(chain_out))
    else $error("chain output moved while link clock high");
  a_latch_gap_met: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(link_clk) |=> (!latch)[*8] ##1 !latch ##1 !latch)
    else $error("latch rose too soon after link clock");
  a_latch_width_min: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(latch) |-> latch[*5])
    else $error("latch pulse too short");
  a_disable_all_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    drive_disable_pin[*8] |-> chan_on_o == 4'h0)
    else $error("channel on while disabled");
  a_reset_pin_clears: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    reset_pin[*8] |-> chan_on_o == 4'h0 && !fault_flag_low_oe)
    else $error("reset pin left channel or fault active");
  a_thermal_all_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    thermal_trip_i[*8] |-> chan_on_o == 4'h0 && fault_flag_low_oe)
    else $error("thermal trip left channel on or fault released");
  a_supply_low_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    supply_low_lockout_i[*8] |-> chan_on_o == 4'h0 && !fault_flag_low_oe)
    else $error("supply lockout left device active");
  c_latch: cover property (@(posedge sys_clk_i) $rose(latch));
  c_fault: cover property (@(posedge sys_clk_i) $rose(fault_flag_low_oe));
  c_disable: cover property (@(posedge sys_clk_i) $rose(drive_disable_pin));
endmodule : switch_link_properties
`default_nettype wire

//--- testbench/test_serial_quad_lowside_switch_ctrl.sv
`default_nettype none
module test_serial_quad_lowside_switch_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import switch_ctrl_pkg::*;
  logic sys_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  chan_t pattern_i = 4'h0;
  logic write_i = 1'h0;
  logic disable_i = 1'h0;
  logic reset_dev_i = 1'h0;
  chan_t overcurrent_trip_i = 4'h0;
  logic thermal_trip_i = 1'h0;
  logic supply_low_lockout_i = 1'h0;
  logic busy_o;
  logic fault_o;
  chan_t chan_on_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  switch_link_if link ();
  switch_host_ctrl switch_host_ctrl_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .pattern_i(pattern_i), .write_i(write_i), .disable_i(disable_i),
    .reset_dev_i(reset_dev_i), .busy_o(busy_o), .fault_o(fault_o), .link(link.host));
  // short retry keeps the run brief but still outlasts a reset wait check
  switch_dev_core #(.RETRY_CYC(2000)) switch_dev_core_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .overcurrent_trip_i(overcurrent_trip_i),
    .thermal_trip_i(thermal_trip_i), .supply_low_lockout_i(supply_low_lockout_i),
    .chan_on_o(chan_on_o), .link(link.device));
  switch_link_properties switch_link_properties_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .supply_low_lockout_i(supply_low_lockout_i),
    .thermal_trip_i(thermal_trip_i), .chan_on_o(chan_on_o), .link_clk(link.link_clk),
    .chain_in(link.chain_in), .chain_out(link.chain_out), .latch(link.latch),
    .drive_disable_pin(link.drive_disable_pin), .reset_pin(link.reset_pin),
    .fault_flag_low_oe(link.fault_flag_low_oe));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc
  task automatic idle_wait();
    int k;
    k = 0;
    while (busy_o !== 1'h0 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask : idle_wait
  task automatic send(input chan_t p);
    idle_wait();
    pattern_i = p;
    write_i = 1'h1;
    cyc(1);
    write_i = 1'h0;
    cyc(2);
    idle_wait();
    cyc(10);
  endtask : send
  ////////////////////////////////////////////////////////////////
  task automatic t_write();
    chan_t pats [4] = '{4'h5, 4'hA, 4'h1, 4'hE};
    foreach (pats[i]) begin
      send(pats[i]);
      check("chan_write", chan_on_o, pats[i]);
    end
    $display("done t_write");
  endtask : t_write
  task automatic t_disable();
    disable_i = 1'h1;
    cyc(8);
    check("chan_dis", chan_on_o, 4'h0);
    send(4'h3);
    check("chan_dis_wr", chan_on_o, 4'h0);
    disable_i = 1'h0;
    cyc(8);
    check("chan_en", chan_on_o, 4'h3);
    $display("done t_disable");
  endtask : t_disable
  task automatic t_fault();
    send(4'hF);
    overcurrent_trip_i = 4'h2;
    cyc(100);
    check("chan_oc", chan_on_o, 4'hD);
    check("fault_oc", {3'h0, fault_o}, 4'h1);
    overcurrent_trip_i = 4'h0;
    cyc(2100);
    check("chan_retry", chan_on_o, 4'hF);
    check("fault_retry", {3'h0, fault_o}, 4'h0);
    overcurrent_trip_i = 4'h4;
    cyc(100);
    overcurrent_trip_i = 4'h0;
    reset_dev_i = 1'h1;
    cyc(1);
    reset_dev_i = 1'h0;
    cyc(20);
    check("fault_rst", {3'h0, fault_o}, 4'h0);
    idle_wait();
    cyc(10);
    check("chan_rst", chan_on_o, 4'h0);
    $display("done t_fault");
  endtask : t_fault
  task automatic t_thermal();
    send(4'h6);
    thermal_trip_i = 1'h1;
    cyc(10);
    check("chan_hot", chan_on_o, 4'h0);
    check("fault_hot", {3'h0, fault_o}, 4'h1);
    thermal_trip_i = 1'h0;
    cyc(10);
    check("chan_cool", chan_on_o, 4'h6);
    check("fault_cool", {3'h0, fault_o}, 4'h0);
    supply_low_lockout_i = 1'h1;
    cyc(10);
    check("chan_uv", chan_on_o, 4'h0);
    supply_low_lockout_i = 1'h0;
    cyc(20);
    check("chan_uv_end", chan_on_o, 4'h0);
    send(4'h9);
    check("chan_uv_wr", chan_on_o, 4'h9);
    $display("done t_thermal");
  endtask : t_thermal
  initial begin
    cyc(3);
    resetn_i = 1'h1;
    t_write();
    t_disable();
    t_fault();
    t_thermal();
    results();
  end
endmodule : test_serial_quad_lowside_switch_ctrl
`default_nettype wire
